// ===== rtl/epwf_map.vh
// register map, field positions, reset values and timing counts
// assumes a 40 MHz core clock and 32-bit word-aligned AHB-Lite registers
`ifndef EPWF_MAP_VH
`define EPWF_MAP_VH

// register byte offsets
`define EPWF_A_CTRL 8'h00
`define EPWF_A_RESOL 8'h04
`define EPWF_A_PRESET 8'h08
`define EPWF_A_OFFSET 8'h0C
`define EPWF_A_SCALE 8'h10
`define EPWF_A_POS 8'h14
`define EPWF_A_IRQ_ST 8'h18
`define EPWF_A_IRQ_MASK 8'h1C
`define EPWF_A_CMD 8'h20
`define EPWF_A_LAMP 8'h24

// control register fields
`define EPWF_F_LEN25 0
`define EPWF_F_NSYS_LO 1
`define EPWF_F_NSYS_HI 2
`define EPWF_F_GRAY 3
`define EPWF_F_SPLIT 4
`define EPWF_F_REVERSE 5
`define EPWF_F_SHIFT_EN 6
`define EPWF_F_SHIFT_LEFT 7
`define EPWF_F_SHAMT_LO 8
`define EPWF_F_SHAMT_HI 11

// number system codes
`define EPWF_NS_TWOS 2'h0
`define EPWF_NS_UNSIGNED 2'h1
`define EPWF_NS_SIGNMAG 2'h2

// interrupt status bits
`define EPWF_I_ZERO 0
`define EPWF_I_PROG 1
`define EPWF_I_NVM 2
`define EPWF_I_POSF 3
`define EPWF_I_FRAME 4

// reset / default values
`define EPWF_R_CTRL 32'h00000000
`define EPWF_R_RESOL 32'h0000CC18
`define EPWF_R_OPTS 32'h00FF0000
`define EPWF_R_SCALE 24'h000001

// timing: figures in their own unit, counts derived from the clock
`define EPWF_CLK_MHZ 40
`define EPWF_CLK_KHZ 16'h9C40
`define EPWF_REPEAT_MS 500
`define EPWF_BLINK_ON_MS 150
`define EPWF_BLINK_OFF_MS 150
`define EPWF_ZERO_FLASH_MS 200
`define EPWF_MONO_US 20
`define EPWF_MONO_CYC (`EPWF_MONO_US * `EPWF_CLK_MHZ)

`endif

// ===== rtl/epwf_lamps.v
// red lamp sequencer: blink codes with repeat pause and zero-confirm flash
// assumes a one-cycle millisecond tick and fault code from the same clock
`timescale 1ns/1ps
`include "epwf_map.vh"

module epwf_lamps (
  input wire clk_i,
  input wire rst_i,
  input wire ms_tick_i,
  input wire [1:0] fault_code_i,
  input wire zero_flash_i,
  output reg lamp_o
);

  localparam [4:0] L_IDLE = 5'b00001;
  localparam [4:0] L_ON = 5'b00010;
  localparam [4:0] L_OFF = 5'b00100;
  localparam [4:0] L_REPEAT = 5'b01000;
  localparam [4:0] L_FLASH = 5'b10000;

  reg [4:0] state_ff;
  reg [4:0] nxt_state;
  reg [9:0] ms_ff;
  reg [9:0] nxt_ms;
  reg [1:0] left_ff;
  reg [1:0] nxt_left;
  reg pend_ff;

  // zero confirm request held until the flash starts, set wins
  always @(posedge clk_i) begin
    if (rst_i)
      pend_ff <= 1'b0;
    else
      pend_ff <= zero_flash_i | (pend_ff & (state_ff != L_IDLE));
  end

  // blink sequence
  always @* begin
    nxt_state = state_ff;
    nxt_ms = ms_ff;
    nxt_left = left_ff;
    case (state_ff)
      L_IDLE: begin
        nxt_ms = 10'h000;
        if (pend_ff) begin
          nxt_state = L_FLASH;
        end else if (fault_code_i != 2'h0) begin
          nxt_left = fault_code_i;
          nxt_state = L_ON;
        end
      end
      L_ON: begin
        if (ms_tick_i) begin
          nxt_ms = ms_ff + 10'h001;
          if (ms_ff == `EPWF_BLINK_ON_MS - 1) begin
            nxt_ms = 10'h000;
            nxt_left = left_ff - 2'h1;
            nxt_state = (left_ff == 2'h1) ? L_REPEAT : L_OFF;
          end
        end
      end
      L_OFF: begin
        if (ms_tick_i) begin
          nxt_ms = ms_ff + 10'h001;
          if (ms_ff == `EPWF_BLINK_OFF_MS - 1) begin
            nxt_ms = 10'h000;
            nxt_state = L_ON;
          end
        end
      end
      L_REPEAT: begin
        // pause before a persisting fault shows again
        if (ms_tick_i) begin
          nxt_ms = ms_ff + 10'h001;
          if (ms_ff == `EPWF_REPEAT_MS - 1)
            nxt_state = L_IDLE;
        end
      end
      L_FLASH: begin
        if (ms_tick_i) begin
          nxt_ms = ms_ff + 10'h001;
          if (ms_ff == `EPWF_ZERO_FLASH_MS - 1)
            nxt_state = L_IDLE;
        end
      end
      default: begin
        nxt_state = L_IDLE;
      end
    endcase
  end

  // state and lamp registers
  always @(posedge clk_i) begin
    if (rst_i) begin
      state_ff <= L_IDLE;
      ms_ff <= 10'h000;
      left_ff <= 2'h0;
      lamp_o <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      ms_ff <= nxt_ms;
      left_ff <= nxt_left;
      lamp_o <= (nxt_state == L_ON) | (nxt_state == L_FLASH);
    end
  end

endmodule

// ===== rtl/epwf_top.v
// position word formatter: registers, position path, word layout, serial out
// assumes an AHB-Lite master on the core clock and a serial clock from a pin
//
// Register access over AHB-Lite and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`include "epwf_map.vh"

module epwf_top #(
  parameter [15:0] MS_CYCLES = `EPWF_CLK_KHZ
) (
  input wire CORE_CLK_I,
  input wire SYS_RST_I,
  input wire HSEL_I,
  input wire [31:0] HADDR_I,
  input wire [1:0] HTRANS_I,
  input wire HWRITE_I,
  input wire [2:0] HSIZE_I,
  input wire [31:0] HWDATA_I,
  input wire HREADY_I,
  output reg [31:0] HRDATA_O,
  output reg HREADYOUT_O,
  output reg HRESP_O,
  input wire [23:0] POS_DATA_I,
  input wire [6:0] STATUS_BITS_I,
  input wire PROG_FAULT_I,
  input wire NVM_FAULT_I,
  input wire POS_FAULT_I,
  input wire ZERO_BTN_N_I,
  input wire SSI_CLK_I,
  output reg SSI_DATA_O,
  output reg POWER_LED_O,
  output wire ERR_LED_O,
  output reg IRQ_O
);

  localparam [2:0] S_IDLE = 3'b001;
  localparam [2:0] S_SHIFT = 3'b010;
  localparam [2:0] S_MONO = 3'b100;
  localparam [31:0] MONO_FULL = `EPWF_MONO_CYC;
  localparam [9:0] MONO_CYC = MONO_FULL[9:0];

  // configuration registers
  reg [31:0] ctrl_ff;
  reg [31:0] resol_ff;
  reg [31:0] opts_ff;
  reg [23:0] preset_ff;
  reg [23:0] offset_ff;
  reg [23:0] scale_ff;
  reg [23:0] zoff_ff;
  reg [23:0] pos_ff;
  reg [4:0] irq_st_ff;
  reg [4:0] irq_mask_ff;
  // bus data-phase capture
  reg wr_pend_ff;
  reg [7:0] wr_addr_ff;
  // synchronisers and events
  reg btn_s1_ff;
  reg btn_s2_ff;
  reg btn_state_ff;
  reg [7:0] deb_cnt_ff;
  reg zero_ev_ff;
  reg ck_s1_ff;
  reg ck_s2_ff;
  reg ck_s3_ff;
  reg [15:0] ms_cnt_ff;
  reg ms_tick_ff;
  reg [2:0] flt_d_ff;
  // serial output
  reg [2:0] ssi_state_ff;
  reg [31:0] frame_ff;
  reg [5:0] bit_cnt_ff;
  reg [9:0] mono_ff;
  reg frame_done_ff;

  wire addr_ok = (HADDR_I[31:6] == 26'h0) & (HADDR_I[1:0] == 2'h0);
  wire acc = HSEL_I & HTRANS_I[1] & HREADY_I;
  wire wr_now = wr_pend_ff;
  wire [23:0] raw_adj = ctrl_ff[`EPWF_F_REVERSE] ? (24'h000000 - POS_DATA_I) : POS_DATA_I;
  wire ck_rise = ck_s2_ff & ~ck_s3_ff;
  wire ck_fall = ~ck_s2_ff & ck_s3_ff;
  wire [2:0] flt_now = {POS_FAULT_I, NVM_FAULT_I, PROG_FAULT_I};

  // word formatting intermediates
  reg [23:0] ns_val;
  reg [23:0] sh_val;
  reg [23:0] code_val;
  reg [23:0] data24;
  reg [31:0] word;
  reg [4:0] p_bits;
  reg [3:0] st_bits;
  reg [3:0] mt_bits;
  reg [11:0] s_field;
  reg [11:0] m_field;
  reg [6:0] stat7;
  reg [23:0] neg_val;

  // read mux, registered for the data phase
  reg [31:0] rd_mux;
  always @* begin
    rd_mux = 32'h00000000;
    case (HADDR_I[7:0])
      `EPWF_A_CTRL: rd_mux = ctrl_ff;
      `EPWF_A_RESOL: rd_mux = resol_ff;
      `EPWF_A_PRESET: rd_mux = {8'h00, preset_ff};
      `EPWF_A_OFFSET: rd_mux = {8'h00, offset_ff};
      `EPWF_A_SCALE: rd_mux = {8'h00, scale_ff};
      `EPWF_A_POS: rd_mux = {8'h00, pos_ff};
      `EPWF_A_IRQ_ST: rd_mux = {27'h0, irq_st_ff};
      `EPWF_A_IRQ_MASK: rd_mux = {27'h0, irq_mask_ff};
      `EPWF_A_CMD: rd_mux = opts_ff;
      `EPWF_A_LAMP: rd_mux = {24'h0, flt_d_ff, ssi_state_ff, POWER_LED_O, ERR_LED_O};
      default: rd_mux = 32'h00000000;
    endcase
  end

  // bus slave: zero wait states, always OKAY, unmapped reads give zero
  always @(posedge CORE_CLK_I) begin
    if (SYS_RST_I) begin
      HRDATA_O <= 32'h00000000;
      HREADYOUT_O <= 1'b0;
      HRESP_O <= 1'b0;
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= 8'h00;
    end else begin
      HREADYOUT_O <= 1'b1;
      HRESP_O <= 1'b0;
      wr_pend_ff <= acc & HWRITE_I & addr_ok;
      wr_addr_ff <= HADDR_I[7:0];
      if (acc & ~HWRITE_I)
        HRDATA_O <= addr_ok ? rd_mux : 32'h00000000;
    end
  end

  // configuration writes; defaults on reset or on the load command
  always @(posedge CORE_CLK_I) begin
    if (SYS_RST_I | (wr_now & (wr_addr_ff == `EPWF_A_CMD) & HWDATA_I[0])) begin
      ctrl_ff <= `EPWF_R_CTRL;
      resol_ff <= `EPWF_R_RESOL;
      opts_ff <= `EPWF_R_OPTS;
      preset_ff <= 24'h000000;
      offset_ff <= 24'h000000;
      scale_ff <= `EPWF_R_SCALE;
      zoff_ff <= 24'h000000;
    end else begin
      if (zero_ev_ff)
        zoff_ff <= 24'h000000 - raw_adj - offset_ff;
      if (wr_now) begin
        case (wr_addr_ff)
          `EPWF_A_CTRL: ctrl_ff <= {20'h0, HWDATA_I[11:0]};
          `EPWF_A_RESOL: resol_ff <= {16'h0, HWDATA_I[15:8], 3'h0, HWDATA_I[4:0]};
          `EPWF_A_PRESET: begin
            // internal preset is absolute: current value jumps to it
            preset_ff <= HWDATA_I[23:0];
            zoff_ff <= HWDATA_I[23:0] - raw_adj - offset_ff;
          end
          `EPWF_A_OFFSET: offset_ff <= HWDATA_I[23:0];
          `EPWF_A_SCALE: scale_ff <= HWDATA_I[23:0];
          `EPWF_A_CMD: opts_ff <= {8'h0, HWDATA_I[23:16], 5'h0, HWDATA_I[10:0]};
          default: ctrl_ff <= ctrl_ff;
        endcase
      end
    end
  end

  // current position: counted value plus zero correction and offset
  always @(posedge CORE_CLK_I) begin
    if (SYS_RST_I)
      pos_ff <= 24'h000000;
    else
      pos_ff <= raw_adj + zoff_ff + offset_ff;
  end

  // millisecond enable for debounce and lamp timing
  always @(posedge CORE_CLK_I) begin
    if (SYS_RST_I) begin
      ms_cnt_ff <= 16'h0000;
      ms_tick_ff <= 1'b0;
    end else begin
      ms_tick_ff <= (ms_cnt_ff == MS_CYCLES - 16'h0001);
      ms_cnt_ff <= (ms_cnt_ff == MS_CYCLES - 16'h0001) ? 16'h0000 : ms_cnt_ff + 16'h0001;
    end
  end

  // zero button: two-stage sync, then debounce by the programmed ms count
  always @(posedge CORE_CLK_I) begin
    if (SYS_RST_I) begin
      btn_s1_ff <= 1'b1;
      btn_s2_ff <= 1'b1;
      btn_state_ff <= 1'b1;
      deb_cnt_ff <= 8'h00;
      zero_ev_ff <= 1'b0;
    end else begin
      btn_s1_ff <= ZERO_BTN_N_I;
      btn_s2_ff <= btn_s1_ff;
      zero_ev_ff <= 1'b0;
      if (btn_s2_ff == btn_state_ff) begin
        deb_cnt_ff <= 8'h00;
      end else if (ms_tick_ff) begin
        deb_cnt_ff <= deb_cnt_ff + 8'h01;
        if (deb_cnt_ff + 8'h01 >= opts_ff[23:16]) begin
          btn_state_ff <= btn_s2_ff;
          zero_ev_ff <= ~btn_s2_ff;
          deb_cnt_ff <= 8'h00;
        end
      end
    end
  end

  // output word: number system, shift, code, layout, status
  always @* begin
    neg_val = 24'h000000 - pos_ff;
    case (ctrl_ff[`EPWF_F_NSYS_HI:`EPWF_F_NSYS_LO])
      `EPWF_NS_SIGNMAG: ns_val = pos_ff[23] ? {1'b1, neg_val[22:0]} : pos_ff;
      `EPWF_NS_UNSIGNED: ns_val = pos_ff;
      default: ns_val = pos_ff;
    endcase
    if (!ctrl_ff[`EPWF_F_SHIFT_EN])
      sh_val = ns_val;
    else if (ctrl_ff[`EPWF_F_SHIFT_LEFT])
      sh_val = ns_val << ctrl_ff[`EPWF_F_SHAMT_HI:`EPWF_F_SHAMT_LO];
    else
      sh_val = ns_val >> ctrl_ff[`EPWF_F_SHAMT_HI:`EPWF_F_SHAMT_LO];
    code_val = ctrl_ff[`EPWF_F_GRAY] ? (sh_val ^ (sh_val >> 1)) : sh_val;
    p_bits = resol_ff[4:0];
    if (p_bits < 5'd9)
      p_bits = 5'd9;
    else if (p_bits > 5'd24)
      p_bits = 5'd24;
    st_bits = (resol_ff[15:12] > 4'd12) ? 4'd12 : resol_ff[15:12];
    mt_bits = (resol_ff[11:8] > 4'd12) ? 4'd12 : resol_ff[11:8];
    // turn bits 11:0 keep their top bits, turn count 23:12 its low bits: boundary stays put
    s_field = code_val[11:0] & ~(12'hFFF >> st_bits);
    m_field = code_val[23:12] & ~(12'hFFF << mt_bits);
    stat7 = STATUS_BITS_I & opts_ff[6:0];
    if (ctrl_ff[`EPWF_F_SPLIT]) begin
      data24 = {m_field, s_field};
      stat7[6] = 1'b0;
    end else begin
      data24 = code_val << (5'd24 - p_bits);
    end
    word = {data24, stat7, 1'b0};
  end

  // serial clock pin: two stages then an edge tap
  always @(posedge CORE_CLK_I) begin
    if (SYS_RST_I) begin
      ck_s1_ff <= 1'b1;
      ck_s2_ff <= 1'b1;
      ck_s3_ff <= 1'b1;
    end else begin
      ck_s1_ff <= SSI_CLK_I;
      ck_s2_ff <= ck_s1_ff;
      ck_s3_ff <= ck_s2_ff;
    end
  end

  // serial shifter: first falling edge latches, rising edges send MSB first
  always @(posedge CORE_CLK_I) begin
    if (SYS_RST_I) begin
      ssi_state_ff <= S_IDLE;
      frame_ff <= 32'h00000000;
      bit_cnt_ff <= 6'h00;
      mono_ff <= 10'h000;
      SSI_DATA_O <= 1'b1;
      frame_done_ff <= 1'b0;
    end else begin
      frame_done_ff <= 1'b0;
      case (ssi_state_ff)
        S_IDLE: begin
          SSI_DATA_O <= 1'b1;
          if (ck_fall) begin
            frame_ff <= word;
            bit_cnt_ff <= 6'h00;
            ssi_state_ff <= S_SHIFT;
          end
        end
        S_SHIFT: begin
          if (ck_rise) begin
            SSI_DATA_O <= frame_ff[31];
            frame_ff <= {frame_ff[30:0], 1'b0};
            bit_cnt_ff <= bit_cnt_ff + 6'h01;
            if (bit_cnt_ff == (ctrl_ff[`EPWF_F_LEN25] ? 6'd24 : 6'd31)) begin
              ssi_state_ff <= S_MONO;
              mono_ff <= MONO_CYC;
            end
          end
        end
        S_MONO: begin
          // data held low until the clock rests for the monoflop time
          if (ck_rise) begin
            SSI_DATA_O <= 1'b0;
            mono_ff <= MONO_CYC;
          end else if (ck_fall) begin
            mono_ff <= MONO_CYC;
          end else if (mono_ff == 10'h000) begin
            SSI_DATA_O <= 1'b1;
            ssi_state_ff <= S_IDLE;
            frame_done_ff <= 1'b1;
          end else begin
            mono_ff <= mono_ff - 10'h001;
          end
        end
        default: ssi_state_ff <= S_IDLE;
      endcase
    end
  end

  // sticky interrupt status, write one to clear, new events win
  wire [4:0] irq_set = {frame_done_ff, flt_now & ~flt_d_ff, zero_ev_ff};
  wire [4:0] irq_clr = (wr_now & (wr_addr_ff == `EPWF_A_IRQ_ST)) ? HWDATA_I[4:0] : 5'h00;
  always @(posedge CORE_CLK_I) begin
    if (SYS_RST_I) begin
      irq_st_ff <= 5'h00;
      irq_mask_ff <= 5'h00;
      flt_d_ff <= 3'h0;
      IRQ_O <= 1'b0;
      POWER_LED_O <= 1'b0;
    end else begin
      flt_d_ff <= flt_now;
      irq_st_ff <= (irq_st_ff & ~irq_clr) | irq_set;
      if (wr_now & (wr_addr_ff == `EPWF_A_IRQ_MASK))
        irq_mask_ff <= HWDATA_I[4:0];
      IRQ_O <= |(irq_st_ff & irq_mask_ff);
      POWER_LED_O <= 1'b1;
    end
  end

  // blink code: data fault 3, memory fault 2, port fault 1
  wire [1:0] fault_code = flt_d_ff[2] ? 2'h3 : (flt_d_ff[1] ? 2'h2 : {1'b0, flt_d_ff[0]});

  // red lamp sequencer
  epwf_lamps u_lamps (
    .clk_i(CORE_CLK_I),
    .rst_i(SYS_RST_I),
    .ms_tick_i(ms_tick_ff),
    .fault_code_i(fault_code),
    .zero_flash_i(zero_ev_ff),
    .lamp_o(ERR_LED_O)
  );

endmodule

// ===== dv/epwf_top_sva.sv
// checker for the position word formatter: lamps, bus answer and serial line
// assumes it is bound to the top module and sees only that module's ports
`timescale 1ns/1ps

module epwf_top_sva #(
  parameter int MS_CYCLES = 40000
) (
  input wire CORE_CLK_I,
  input wire SYS_RST_I,
  input wire PROG_FAULT_I,
  input wire NVM_FAULT_I,
  input wire POS_FAULT_I,
  input wire ZERO_BTN_N_I,
  input wire SSI_CLK_I,
  input wire SSI_DATA_O,
  input wire HREADYOUT_O,
  input wire HRESP_O,
  input wire POWER_LED_O,
  input wire ERR_LED_O,
  input wire IRQ_O
);
  localparam int SAT = 3000 * MS_CYCLES;
  int quiet_ff;
  int dark_ff;
  int btn_ff;
  int nofault_ff;
  wire any_fault = PROG_FAULT_I | NVM_FAULT_I | POS_FAULT_I;

  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (SYS_RST_I);

  // saturating span counter, cleared by its condition
  function automatic int step(input int c, input logic clr);
    return clr ? 0 : ((c < SAT) ? c + 1 : c);
  endfunction

  // spans: quiet, dark while faulty, button held, free of faults
  always @(posedge CORE_CLK_I) begin
    quiet_ff <= step(quiet_ff, SYS_RST_I | any_fault | ~ZERO_BTN_N_I);
    dark_ff <= step(dark_ff, SYS_RST_I | ~any_fault | ERR_LED_O);
    btn_ff <= step(btn_ff, SYS_RST_I | ZERO_BTN_N_I);
    nofault_ff <= step(nofault_ff, SYS_RST_I | any_fault);
  end

  a_resp_okay: assert property (HRESP_O == 1'b0)
    else $error("bus answer was not okay");
  a_ready_after: assert property (!$past(SYS_RST_I) |-> HREADYOUT_O)
    else $error("bus not ready after reset");
  a_power_lamp: assert property (!$past(SYS_RST_I) |-> POWER_LED_O)
    else $error("green lamp dark while running");
  a_lamp_quiet: assert property (quiet_ff >= 1600 * MS_CYCLES |-> !ERR_LED_O)
    else $error("red lamp lit without fault");
  a_blink_repeat: assert property (dark_ff < 700 * MS_CYCLES)
    else $error("fault pattern not repeated in time");
  a_zero_wait: assert property (btn_ff == 250 * MS_CYCLES &&
      nofault_ff > 2000 * MS_CYCLES |-> !ERR_LED_O)
    else $error("zero flash before debounce ended");
  a_zero_flash: assert property (btn_ff == 265 * MS_CYCLES &&
      nofault_ff > 2000 * MS_CYCLES |-> ERR_LED_O)
    else $error("no zero flash after debounce");
  a_data_moves: assert property ($changed(SSI_DATA_O) |->
      $past(SSI_CLK_I, 2) || $past(SSI_CLK_I, 3) || $past(SSI_CLK_I, 4))
    else $error("serial data moved in a low clock phase");

  c_blink: cover property ($rose(ERR_LED_O));
  c_frame: cover property ($fell(SSI_DATA_O));
  c_irq: cover property ($rose(IRQ_O));
endmodule

bind epwf_top epwf_top_sva #(.MS_CYCLES(MS_CYCLES)) i_epwf_top_sva (.*);

// ===== dv/epwf_ssi_ctrl.sv
// serial controller model: clocks one position word out per call
// assumes the data line returns high within 40 us after each frame
`timescale 1ns/1ps

module epwf_ssi_ctrl (
  output logic ssi_clk_o,
  input wire logic ssi_data_i
);
  // clock stands high between frames
  initial ssi_clk_o = 1'b1;

  // fall latches, each rise shifts, sample at end of the low phase
  task automatic read_word(input int nbits, output logic [31:0] w, output logic tail);
    int k;
    w = 32'h0;
    #37 ssi_clk_o = 1'b0;
    #100;
    for (k = 0; k < nbits; k++) begin
      ssi_clk_o = 1'b1;
      #100 ssi_clk_o = 1'b0;
      #100 w[31-k] = ssi_data_i;
    end
    ssi_clk_o = 1'b1;
    #200 tail = ssi_data_i;
    // wait for idle level before another frame
    for (k = 0; k < 400 && ssi_data_i !== 1'b1; k++) #100;
  endtask
endmodule

// ===== dv/encoder_position_word_formatter_tb_top.sv
// top testbench of the position word formatter: bus tasks and word checks
// assumes the serial controller model and the bound checker
`timescale 1ns/1ps
`include "epwf_map.vh"

module encoder_position_word_formatter_tb_top;
  localparam int MS = 4;
  localparam logic [7:0] DA [6] = '{`EPWF_A_CTRL, `EPWF_A_RESOL, `EPWF_A_PRESET,
    `EPWF_A_OFFSET, `EPWF_A_SCALE, `EPWF_A_CMD};
  localparam logic [31:0] DV [6] = '{32'h0, 32'h0000CC18, 32'h0, 32'h0, 32'h1, 32'h00FF0000};
  localparam logic [31:0] CTL [5] = '{32'h0, 32'h2, 32'h4, 32'h8, 32'h1};
  localparam logic [23:0] NUMV [5] = '{24'hFFFFFE, 24'hFFFFFE, 24'h800002, 24'h800001,
    24'hFFFFFE};
  localparam logic [31:0] RES [3] = '{32'h9, 32'h10, 32'h18};
  localparam logic [23:0] RESV [3] = '{24'h2B0000, 24'h345600, 24'h123456};
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic hsel = 1'b1;
  logic hwrite = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] rd;
  logic [1:0] htrans = 2'h0;
  logic [23:0] pos = 24'h123456;
  logic [6:0] stat = 7'h7F;
  logic [2:0] flt = 3'h0;
  logic btn_n = 1'b1;
  wire [31:0] hrdata;
  wire hready, hresp, ssi_clk, ssi_data, pwr, err, irq;
  int n_errors = 0;
  int comparisons = 0;
  int cyc = 0;

  epwf_top #(.MS_CYCLES(16'(MS))) i_epwf_top (
    .CORE_CLK_I(clk), .SYS_RST_I(rst), .HSEL_I(hsel), .HADDR_I(haddr), .HTRANS_I(htrans),
    .HWRITE_I(hwrite), .HSIZE_I(3'h2), .HWDATA_I(hwdata), .HREADY_I(hready),
    .HRDATA_O(hrdata), .HREADYOUT_O(hready), .HRESP_O(hresp), .POS_DATA_I(pos),
    .STATUS_BITS_I(stat), .PROG_FAULT_I(flt[0]), .NVM_FAULT_I(flt[1]), .POS_FAULT_I(flt[2]),
    .ZERO_BTN_N_I(btn_n), .SSI_CLK_I(ssi_clk), .SSI_DATA_O(ssi_data), .POWER_LED_O(pwr),
    .ERR_LED_O(err), .IRQ_O(irq));

  epwf_ssi_ctrl i_epwf_ssi_ctrl (.ssi_clk_o(ssi_clk), .ssi_data_i(ssi_data));

  // 40 MHz core clock
  always #12.5 clk = ~clk;

  // cut a hang short
  always @(posedge clk) begin
    cyc++;
    if (cyc == 90000) begin
      n_errors++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one single transfer; waits on ready in both phases
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] wd);
    @(posedge clk);
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    ahb(1'b1, a, d);
  endtask

  task automatic rchk(input string what, input logic [31:0] a, input logic [31:0] m,
      input logic [31:0] exp);
    ahb(1'b0, a, 32'h0);
    chk(what, exp, rd & m);
  endtask

  task automatic frame(input int n, input logic [31:0] exp);
    logic [31:0] w;
    logic tail;
    i_epwf_ssi_ctrl.read_word(n, w, tail);
    chk("word", exp, w);
    chk("tail", 32'h0, {31'h0, tail});
  endtask

  initial begin
    int n;
    logic lit;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    // defaults, unmapped place, raw position
    for (int i = 0; i < 6; i++)
      rchk("default", {24'h0, DA[i]}, 32'hFFFFFFFF, DV[i]);
    wr(32'h3C, 32'hFFFFFFFF);
    rchk("unmapped", 32'h3C, 32'hFFFFFFFF, 32'h0);
    rchk("position", `EPWF_A_POS, 32'hFFFFFF, 32'h123456);
    $display("test defaults finished");
    // number systems, gray code and both lengths, status disabled
    @(posedge clk) pos <= 24'hFFFFFE;
    for (int i = 0; i < 5; i++) begin
      wr(`EPWF_A_CTRL, CTL[i]);
      frame(CTL[i][0] ? 25 : 32, {NUMV[i], 8'h00});
    end
    // msb-justified resolutions and value shift both ways
    @(posedge clk) pos <= 24'h123456;
    wr(`EPWF_A_CTRL, 32'h0);
    for (int i = 0; i < 3; i++) begin
      wr(`EPWF_A_RESOL, 32'h0000CC00 | RES[i]);
      frame(32, {RESV[i], 8'h00});
    end
    wr(`EPWF_A_RESOL, 32'h0000CC18);
    wr(`EPWF_A_CTRL, 32'h4C0);
    frame(32, {24'h234560, 8'h00});
    wr(`EPWF_A_CTRL, 32'h440);
    frame(32, {24'h012345, 8'h00});
    $display("test word formats finished");
    // split layout with status bits on, pulse 25 kept clear
    @(posedge clk) pos <= 24'hABC123;
    wr(`EPWF_A_CMD, 32'h00FF007E);
    wr(`EPWF_A_CTRL, 32'h2);
    frame(32, {24'hABC123, 7'h7E, 1'b0});
    wr(`EPWF_A_CTRL, 32'h12);
    wr(`EPWF_A_RESOL, 32'h00009B00);
    frame(32, {24'h2BC120, 7'h3E, 1'b0});
    wr(`EPWF_A_RESOL, 32'h0000CC00);
    frame(32, {24'hABC123, 7'h3E, 1'b0});
    $display("test split layout finished");
    // load in order, then preset, zero button and its interrupt
    wr(`EPWF_A_CMD, 32'h1);
    wr(`EPWF_A_CTRL, 32'h0);
    wr(`EPWF_A_SCALE, 32'h1);
    wr(`EPWF_A_PRESET, 32'h100);
    wr(`EPWF_A_CMD, 32'h00FF0000);
    rchk("preset", `EPWF_A_POS, 32'hFFFFFF, 32'h100);
    wr(`EPWF_A_OFFSET, 32'h10);
    rchk("offset", `EPWF_A_POS, 32'hFFFFFF, 32'h110);
    chk("irq masked", 32'h0, {31'h0, irq});
    wr(`EPWF_A_IRQ_MASK, 32'h1);
    @(posedge clk) btn_n <= 1'b0;
    repeat (300 * MS) @(posedge clk);
    btn_n <= 1'b1;
    rchk("zeroed", `EPWF_A_POS, 32'hFFFFFF, 32'h0);
    rchk("zero event", `EPWF_A_IRQ_ST, 32'h1, 32'h1);
    chk("irq on", 32'h1, {31'h0, irq});
    wr(`EPWF_A_IRQ_ST, 32'h1);
    repeat (2) @(posedge clk);
    chk("irq off", 32'h0, {31'h0, irq});
    $display("test zero button finished");
    // each fault blinks its count and raises its event
    repeat (300 * MS) @(posedge clk);
    for (int f = 1; f <= 3; f++) begin
      n = 0;
      lit = 1'b0;
      @(posedge clk) flt <= 3'h1 << (f - 1);
      repeat ((f * 300 + 300) * MS) begin
        @(posedge clk);
        n += (err === 1'b1 && !lit);
        lit = (err === 1'b1);
      end
      chk("blinks", f, n);
      rchk("fault event", `EPWF_A_IRQ_ST, 32'h1 << f, 32'h1 << f);
      @(posedge clk) flt <= 3'h0;
      repeat (1600 * MS) @(posedge clk);
    end
    $display("test fault lamps finished");
    give_verdict();
  end
endmodule
